// ### rtl/tofrr_pkg.sv
// Overview of operation
// R1: Tap at peak plus 250 ns readable.
// R2: Offset 0x79 holds peak plus 500 ns.
// R3: Offset 0x7A holds peak plus 750 ns.
// R4: Offset 0x7B holds peak plus 1000 ns.
// R5: Taps 8-bit, reset zero, only when enabled.
// R6: Offset 0x7C holds signed angle estimate.
// R7: First estimate loaded at header detection.
// R8: Accumulated estimate published at frame end.
// R9: Flight counter advances at 16 MHz.
// R10: Offset 0x7D returns count bits 7:0.
// R11: Offset 0x7E returns count bits 15:8.
// R12: Offset 0x7F returns count bits 23:16.
// R13: Earlier taps from minus 1000 ns.
// R14: Writes to result registers are ignored.
package tofrr_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CORR_FIRST        = 8'h73;
    localparam logic [7:0] ADDR_CORR_MAG_PLUS_250 = 8'h78;
    localparam logic [7:0] ADDR_CORR_MAG_PLUS_500 = 8'h79;
    localparam logic [7:0] ADDR_CORR_MAG_PLUS_750 = 8'h7a;
    localparam logic [7:0] ADDR_CORR_MAG_PLUS_1000 = 8'h7b;
    localparam logic [7:0] ADDR_FREQ_OFFSET_EST   = 8'h7c;
    localparam logic [7:0] ADDR_FLIGHT_COUNT_LOW  = 8'h7d;
    localparam logic [7:0] ADDR_FLIGHT_COUNT_MID  = 8'h7e;
    localparam logic [7:0] ADDR_FLIGHT_COUNT_HIGH = 8'h7f;
    localparam logic [7:0] RESULT_RESET           = 8'h00;

    // ------------------------------------------------------------------
    // Correlator window and timing
    // ------------------------------------------------------------------
    localparam int CORR_TAPS      = 9;
    localparam int CORR_POST_TAPS = 4;
    localparam int TAP_STEP_NS    = 250;
    localparam int CORE_CLK_KHZ   = 125000;
    localparam int TOF_CLK_KHZ    = 16000;
    localparam int TOF_WIDTH      = 24;
    localparam int FO_SHIFT       = 2;
endpackage

// ### rtl/tofrr_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tofrr_result_regs (
    input  wire logic                         core_clk,
    input  wire logic                         srst,
    input  wire logic                         flight_measure_enable,
    input  wire logic                         corr_mag_valid,
    input  wire logic [7:0]                   corr_mag,
    input  wire logic                         corr_peak,
    input  wire logic                         fo_valid,
    input  wire logic signed [7:0]            fo_sample,
    input  wire logic                         phr_detected,
    input  wire logic                         frame_end,
    input  wire logic                         tof_start,
    input  wire logic                         tof_stop,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic                         reg_wr,
    input  wire logic [7:0]                   reg_wdata,
    input  wire logic                         reg_rd,
    output logic [7:0]                        reg_rdata,
    output logic                              reg_rdata_valid,
    output logic [tofrr_pkg::TOF_WIDTH-1:0]   flight_count_live
);
    import tofrr_pkg::*;

    localparam logic [7:0] TOF_INC = 8'(TOF_CLK_KHZ / 1000);
    localparam logic [7:0] TOF_MOD = 8'(CORE_CLK_KHZ / 1000);

    // Refused at elaboration: the accumulator only divides whole-MHz rates below the core clock.
    if (TOF_CLK_KHZ >= CORE_CLK_KHZ
        || CORE_CLK_KHZ % 1000 != 0
        || TOF_CLK_KHZ % 1000 != 0) begin : g_bad_time_base
        $error("Flight time base must be a slower whole-MHz fraction of the core clock.");
    end

    // ------------------------------------------------------------------
    // Correlator window
    // ------------------------------------------------------------------
    logic [7:0] win     [0:CORR_TAPS-1];
    logic [7:0] corr_res [0:CORR_TAPS-1];
    logic       post_pending;
    logic [2:0] post_cnt;
    logic       cap_strobe;

    // Newest sample sits in win[0]; the peak is four steps of 250 ns back.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            win[0] <= RESULT_RESET;
        end else if (corr_mag_valid) begin
            win[0] <= corr_mag;
        end
    end

    generate
        for (genvar i = 1; i < CORR_TAPS; i++) begin : g_shift
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    win[i] <= RESULT_RESET;
                end else if (corr_mag_valid) begin
                    win[i] <= win[i-1];
                end
            end
        end
    endgenerate

    // Count strobes after the peak; the window is taken once it is centred.
    always_ff @(posedge core_clk) begin
        if (srst || !flight_measure_enable) begin
            post_pending <= 1'b0;
            post_cnt     <= 3'h0;
        end else if (corr_mag_valid && corr_peak) begin
            post_pending <= 1'b1;
            post_cnt     <= 3'h0;
        end else if (corr_mag_valid && post_pending) begin
            post_cnt <= post_cnt + 3'h1;
            if (post_cnt == 3'(CORR_POST_TAPS - 1)) begin
                post_pending <= 1'b0;
            end
        end
    end

    assign cap_strobe = corr_mag_valid && post_pending && !corr_peak && post_cnt == 3'(CORR_POST_TAPS - 1);

    // Tap k holds the sample at (k-4) * 250 ns from the peak. [R1] [R2] [R3] [R4] [R13]
    generate
        for (genvar k = 0; k < CORR_TAPS; k++) begin : g_taps
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    corr_res[k] <= RESULT_RESET; // [R5]
                end else if (cap_strobe) begin
                    if (k == CORR_TAPS - 1) begin
                        corr_res[k] <= corr_mag;
                    end else begin
                        corr_res[k] <= win[CORR_TAPS - 2 - k];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Frequency offset estimate
    // ------------------------------------------------------------------
    logic signed [7:0] fo_accum;
    logic signed [7:0] fo_result;
    logic              fo_active;
    logic signed [8:0] fo_diff;

    assign fo_diff = 9'(fo_sample) - 9'(fo_accum);

    // A running average smooths the estimate without a divider; the sample stays in the signed angle range. [R6]
    always_ff @(posedge core_clk) begin
        if (srst || !flight_measure_enable) begin
            fo_accum  <= RESULT_RESET;
            fo_active <= 1'b0;
        end else if (phr_detected) begin
            fo_accum  <= fo_valid ? fo_sample : fo_accum;
            fo_active <= 1'b1;
        end else if (frame_end) begin
            fo_active <= 1'b0;
        end else if (fo_active && fo_valid) begin
            fo_accum <= fo_accum + 8'(fo_diff >>> FO_SHIFT); // [R8]
        end
    end

    // Header detection loads the first estimate, frame end the refined one.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fo_result <= RESULT_RESET;
        end else if (flight_measure_enable && phr_detected && fo_valid) begin
            fo_result <= fo_sample; // [R7]
        end else if (flight_measure_enable && fo_active && frame_end) begin
            fo_result <= fo_accum; // [R8]
        end
    end

    // ------------------------------------------------------------------
    // Flight time counter
    // ------------------------------------------------------------------
    logic [7:0]           tof_phase;
    logic [8:0]           next_tof_phase;
    logic                 tof_tick;
    logic                 tof_running;
    logic [TOF_WIDTH-1:0] tof_result;

    // A fractional accumulator gives 16 ticks per microsecond with no second clock.
    assign next_tof_phase = 9'(tof_phase) + 9'(TOF_INC);
    assign tof_tick       = next_tof_phase >= 9'(TOF_MOD);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tof_phase <= 8'h00;
        end else if (tof_tick) begin
            tof_phase <= 8'(next_tof_phase - 9'(TOF_MOD)); // [R9]
        end else begin
            tof_phase <= next_tof_phase[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !flight_measure_enable) begin
            tof_running       <= 1'b0;
            flight_count_live <= '0;
        end else if (tof_start) begin
            tof_running       <= 1'b1;
            flight_count_live <= '0;
        end else if (tof_stop) begin
            tof_running <= 1'b0;
        end else if (tof_running && tof_tick) begin
            flight_count_live <= flight_count_live + 24'h000001; // [R9]
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tof_result <= '0;
        end else if (flight_measure_enable && tof_running && tof_stop) begin
            tof_result <= flight_count_live;
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        logic [7:0] r;
        r = 8'h00;
        if (addr >= ADDR_CORR_FIRST && addr <= ADDR_CORR_MAG_PLUS_1000) begin
            r = corr_res[4'(addr - ADDR_CORR_FIRST)];
        end else if (addr == ADDR_FREQ_OFFSET_EST) begin
            r = fo_result;
        end else if (addr == ADDR_FLIGHT_COUNT_LOW) begin
            r = tof_result[7:0]; // [R10]
        end else if (addr == ADDR_FLIGHT_COUNT_MID) begin
            r = tof_result[15:8]; // [R11]
        end else if (addr == ADDR_FLIGHT_COUNT_HIGH) begin
            r = tof_result[23:16]; // [R12]
        end
        return r;
    endfunction

    // Results are hidden while measurement mode is off; writes have no path in. [R5] [R14]
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata       <= 8'h00;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= flight_measure_enable ? read_mux(reg_addr) : 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_rdata_disabled: assert property (@(posedge core_clk) disable iff (srst) // [R5]
        reg_rd && !flight_measure_enable |=> reg_rdata == 8'h00 && reg_rdata_valid)
        else $error("Read while disabled returned data.");

    a_tick_spacing: assert property (@(posedge core_clk) disable iff (srst) // [R9]
        tof_tick |=> (!tof_tick)[*6] ##[1:2] tof_tick)
        else $error("Flight time base not at 16 MHz.");

    a_count_low_read: assert property (@(posedge core_clk) disable iff (srst) // [R10]
        reg_rd && flight_measure_enable && reg_addr == ADDR_FLIGHT_COUNT_LOW |=> reg_rdata == $past(tof_result[7:0]))
        else $error("Low count byte wrong.");

    a_count_mid_read: assert property (@(posedge core_clk) disable iff (srst) // [R11]
        reg_rd && flight_measure_enable && reg_addr == ADDR_FLIGHT_COUNT_MID |=> reg_rdata == $past(tof_result[15:8]))
        else $error("Middle count byte wrong.");

    a_count_high_read: assert property (@(posedge core_clk) disable iff (srst) // [R12]
        reg_rd && flight_measure_enable && reg_addr == ADDR_FLIGHT_COUNT_HIGH |=> reg_rdata == $past(tof_result[23:16]))
        else $error("High count byte wrong.");

    a_fo_header_load: assert property (@(posedge core_clk) disable iff (srst) // [R7]
        flight_measure_enable && phr_detected && fo_valid |=> fo_result == $past(fo_sample))
        else $error("First estimate not loaded at header.");

    a_fo_frame_end: assert property (@(posedge core_clk) disable iff (srst) // [R8]
        flight_measure_enable && fo_active && frame_end && !phr_detected |=> fo_result == $past(fo_accum))
        else $error("Accumulated estimate not published.");

    a_plus500_tap: assert property (@(posedge core_clk) disable iff (srst) // [R2]
        cap_strobe |=> corr_res[6] == $past(win[1]) && corr_res[4] == $past(win[3]))
        else $error("Window not centred on peak.");

    a_plus1000_tap: assert property (@(posedge core_clk) disable iff (srst) // [R4]
        cap_strobe |=> corr_res[8] == $past(corr_mag) && corr_res[0] == $past(win[7]))
        else $error("Window edge taps wrong.");

    a_write_ignored: assert property (@(posedge core_clk) disable iff (srst) // [R14]
        reg_wr && !cap_strobe && !phr_detected && !frame_end && !tof_stop
        |=> $stable(fo_result) && $stable(tof_result) && $stable(corr_res[5]))
        else $error("Write changed a result register.");

    a_capture_delay: assert property (@(posedge core_clk) disable iff (srst) // [R1]
        corr_mag_valid && corr_peak && flight_measure_enable |=> post_pending && post_cnt == 3'h0)
        else $error("Peak not armed for capture.");
endmodule
`default_nettype wire

// ### verif/tof_result_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Result register bench
// ----------------------------------------
module tof_result_registers_test;
    import tofrr_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b0;
    logic cv = 1'b0, pk = 1'b0, fv = 1'b0, phr = 1'b0, fe = 1'b0, t0 = 1'b0, t1 = 1'b0;
    logic [7:0] cm = 8'h00, fs = 8'h00, a, wd, rdat, d0, d1, d2;
    logic wr, rd, rv, v;
    logic [TOF_WIDTH-1:0] live;
    int failures = 0;
    int tests_run = 0;
    int acc;

    always #4 core_clk = ~core_clk;

    tofrr_result_regs tofrr_result_regs_i (.core_clk(core_clk), .srst(srst),
        .flight_measure_enable(en), .corr_mag_valid(cv), .corr_mag(cm), .corr_peak(pk),
        .fo_valid(fv), .fo_sample(fs), .phr_detected(phr), .frame_end(fe), .tof_start(t0),
        .tof_stop(t1), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
        .reg_rdata(rdat), .reg_rdata_valid(rv), .flight_count_live(live));
    tofrr_host_model tofrr_host_model_i (.core_clk(core_clk), .reg_addr(a), .reg_wr(wr),
        .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdat), .reg_rdata_valid(rv));

    task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // A read must answer with a valid pulse and the expected byte.
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        tofrr_host_model_i.rd(ad, d0, v);
        check("rdata_valid", {23'h0, v}, 24'h1);
        check($sformatf("reg %h", ad), {16'h0, d0}, {16'h0, e});
    endtask

    // Correlator steps come every 250 ns, about 31 core cycles.
    task automatic strobe(input logic [7:0] m, input logic p);
        @(posedge core_clk);
        #1;
        {cm, cv, pk} = {m, 1'b1, p};
        @(posedge core_clk);
        #1;
        {cv, pk} = 2'b00;
        repeat (29) @(posedge core_clk);
    endtask

    task automatic fo(input logic [7:0] s, input logic h);
        @(posedge core_clk);
        #1;
        {fs, fv, phr} = {s, 1'b1, h};
        @(posedge core_clk);
        #1;
        {fv, phr} = 2'b00;
        if (!h) acc = acc + ((int'($signed(s)) - acc) >>> FO_SHIFT);
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog sized well past the roughly 4400 cycles the tests need.
    initial begin
        #150us;
        failures++;
        finish_test();
    end

    // Main sequence: reset values, taps, write refusal, offset, flight time.
    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        srst = 1'b0;
        en = 1'b1;
        for (int i = 8'h73; i <= 8'h7f; i++) rchk(8'(i), RESULT_RESET);
        check("live reset", live, 24'h0);
        $display("test reset done");
        for (int i = 0; i < CORR_TAPS; i++) strobe((i == 8) ? 8'hff : 8'(8'h11 * (i + 1)), i == 4);
        for (int i = 0; i < CORR_TAPS; i++)
            rchk(8'(8'h73 + i), (i == 8) ? 8'hff : 8'(8'h11 * (i + 1)));
        tofrr_host_model_i.wr(ADDR_CORR_MAG_PLUS_500, 8'h5a);
        rchk(ADDR_CORR_MAG_PLUS_500, 8'h77);
        en = 1'b0;
        rchk(ADDR_CORR_MAG_PLUS_500, 8'h00);
        en = 1'b1;
        $display("test correlator done");
        acc = -40;
        fo(8'hd8, 1'b1);
        rchk(ADDR_FREQ_OFFSET_EST, 8'hd8);
        fo(8'h14, 1'b0);
        fo(8'h14, 1'b0);
        rchk(ADDR_FREQ_OFFSET_EST, 8'hd8);
        @(posedge core_clk);
        #1;
        fe = 1'b1;
        @(posedge core_clk);
        #1;
        fe = 1'b0;
        rchk(ADDR_FREQ_OFFSET_EST, 8'(acc));
        $display("test offset done");
        // 4000 cycles at 125 MHz span 512 ticks of the 16 MHz base.
        @(posedge core_clk);
        #1;
        t0 = 1'b1;
        @(posedge core_clk);
        #1;
        t0 = 1'b0;
        repeat (3999) @(posedge core_clk);
        #1;
        t1 = 1'b1;
        @(posedge core_clk);
        #1;
        t1 = 1'b0;
        tofrr_host_model_i.rd(ADDR_FLIGHT_COUNT_LOW, d0, v);
        tofrr_host_model_i.rd(ADDR_FLIGHT_COUNT_MID, d1, v);
        tofrr_host_model_i.rd(ADDR_FLIGHT_COUNT_HIGH, d2, v);
        check("flight near 512", 24'({d2, d1, d0} >= 511 && {d2, d1, d0} <= 513), 24'h1);
        check("live near 512", 24'(live >= 511 && live <= 513), 24'h1);
        check("flight high", {16'h0, d2}, 24'h0);
        $display("test flight done");
        finish_test();
    end
endmodule
`default_nettype wire

// ### verif/tofrr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module tofrr_host_model (
    input  wire logic       core_clk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rdata_valid
);
    // Idle port: no strobes raised before the bench asks for one.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // One read: held across the taking edge, answer taken in the next cycle.
    // The address is inverted on release so a stale value never looks valid.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        v = reg_rdata_valid;
    endtask

    // One write, which the device is expected to discard.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
endmodule
`default_nettype wire
